/* sfcd_regs.vh */
// sfcd_regs.vh: opcodes, field positions, reset values and timing counts
// for the serial flash command decoder; definitions only, no logic.
`ifndef SFCD_REGS_VH
`define SFCD_REGS_VH
// ==========================================================================
// operation codes
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR 8'h05
`define OP_WRSR 8'h01
`define OP_RDLR 8'hE8
`define OP_WRLR 8'hE5
`define OP_RDFSR 8'h70
`define OP_CLFSR 8'h50
`define OP_RDNVCR 8'hB5
`define OP_WRNVCR 8'hB1
`define OP_RDVCR 8'h85
`define OP_WRVCR 8'h81
`define OP_RDEVCR 8'h65
`define OP_WREVCR 8'h61
`define OP_RDEAR 8'hC8
`define OP_WREAR 8'hC5
`define OP_PP 8'h02
`define OP_PP4 8'h12
`define OP_DIFP 8'hA2
`define OP_DIFP_X 8'hD2
`define OP_QIFP 8'h32
`define OP_QIFP4 8'h34
`define OP_QIFP_X 8'h38
`define OP_SSE 8'h20
`define OP_SE 8'hD8
`define OP_BE 8'hC7
`define OP_RESUME 8'h7A
`define OP_SUSPEND 8'h75
`define OP_RDOTP 8'h4B
`define OP_PROTP 8'h42
`define OP_EN4B 8'hB7
`define OP_EX4B 8'hE9
// ==========================================================================
// protocol encodings
`define PROTO_EXT 2'h0
`define PROTO_DUAL 2'h1
`define PROTO_QUAD 2'h2
// ==========================================================================
// field positions and reset values
`define SR_WIP 0
`define SR_WEL 1
`define FSR_ADDR4 0
`define FSR_PROT 1
`define FSR_PROG 4
`define FSR_ERASE 5
`define FSR_PEC 7
`define NVCR_RESET 16'hFFFF
`define VCR_RESET 8'hFB
`define EVCR_RESET 8'hFF
`define EAR_RESET 8'h00
`define LOCK_RESET 8'h00
// ==========================================================================
// timing counts
`define PAGE_BYTES 256
`define OTP_BYTES 64
`define OTP_DUMMY_EXT 4'h8
`define OTP_DUMMY_QUAD 4'hA
`endif

/* sfcd_sync.v */
// sfcd_sync.v: two flip-flop synchroniser for a bus of pin levels.
// assumes the input is asynchronous to clk.
`timescale 1ns/10ps
module sfcd_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	// ======================================================================
	// synchroniser stages
	reg [W-1:0] meta; // first stage, read only by q
	// two stages; reset value is the idle pin level zero
	always @(posedge clk) begin
		if (rst) begin
			meta <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // sfcd_sync

/* sfcd_shift.v */
// sfcd_shift.v: nibble-wide shift-in / shift-out unit for 1, 2 or 4 lines.
// assumes step pulses come from sclk edges already detected in clk domain.
`timescale 1ns/10ps
`include "sfcd_regs.vh"
module sfcd_shift (
	input wire clk,
	input wire rst,
	input wire clear,
	input wire [1:0] proto,
	input wire in_step,
	input wire [3:0] din,
	input wire out_step,
	input wire load,
	input wire [7:0] load_byte,
	output reg [7:0] in_byte,
	output reg byte_done,
	output reg [3:0] dout
);
	// ======================================================================
	// state
	reg [2:0] bitcnt; // bits received in current byte
	reg [7:0] out_sr; // outgoing byte, msb first
	wire [2:0] width = (proto == `PROTO_QUAD) ? 3'd4 : (proto == `PROTO_DUAL) ? 3'd2 : 3'd1;
	wire [7:0] shifted = (proto == `PROTO_QUAD) ? {in_byte[3:0], din} :
		(proto == `PROTO_DUAL) ? {in_byte[5:0], din[1:0]} : {in_byte[6:0], din[0]};
	// receive path: byte_done pulses when eight bits are in
	always @(posedge clk) begin
		if (rst || clear) begin
			bitcnt <= 3'd0;
			in_byte <= 8'h00;
			byte_done <= 1'b0;
		end else begin
			byte_done <= 1'b0;
			if (in_step) begin
				in_byte <= shifted;
				bitcnt <= bitcnt + width;
				byte_done <= ((bitcnt + width) & 3'd7) == 3'd0;
			end
		end
	end
	// transmit path: load only stages the byte; the next drive edge shows
	// its top bits, so the msb is never lost to an unsampled half clock
	always @(posedge clk) begin
		if (rst || clear) begin
			out_sr <= 8'h00;
			dout <= 4'h0;
		end else if (load) begin
			out_sr <= load_byte;
		end else if (out_step) begin
			if (proto == `PROTO_QUAD) begin
				out_sr <= {out_sr[3:0], 4'h0};
				dout <= out_sr[7:4];
			end else if (proto == `PROTO_DUAL) begin
				out_sr <= {out_sr[5:0], 2'b00};
				dout <= {2'b00, out_sr[7:6]};
			end else begin
				// single-line output leaves on the second line
				out_sr <= {out_sr[6:0], 1'b0};
				dout <= {2'b00, out_sr[7], 1'b0};
			end
		end
	end
endmodule // sfcd_shift

/* sfcd_core.v */
// sfcd_core.v: command decoder front end of a serial nor flash.
// assumes SCLK, CS_N and data pins are asynchronous, sampled by SYS_CLK
// well above the link rate; program/erase engines sit outside.
// Function
// - 05h streams status register, always accepted
// - 70h streams flag status, always accepted
// - register and enable opcodes: no address/dummy, lock register excepted
// - 50h clears flag status errors
// - write-type commands need write enable first
// - 01h one byte, E5h one, E8h addressed
// - erases take 3 or 4 address bytes
// - B5h/B1h two bytes, least significant first
// - volatile and enhanced config read/write decoded
// - C8h/C5h extended address, variant skips enable
// - frame opens on chip select fall, per-protocol lines
// - chip select rise stops output and ends
// - page programs accept 1 to 256 bytes
// - 12h/34h always four address bytes
// - 4Bh up to 64 bytes after dummy
// - B7h enters, E9h leaves four-byte addressing
// - dual protocol aliases 02h/A2h/D2h
// - quad protocol aliases 02h/32h/variant code
// - error flags sticky until clear command
// - nonvolatile read pads zeros after sixteen bits
`timescale 1ns/10ps
`include "sfcd_regs.vh"
module sfcd_core #(
	parameter ALT_VARIANT = 1'b0, // variant with reset pin, uses 38h alias
	parameter [3:0] OTP_DUMMY_CFG = 4'd0 // nonzero overrides dummy count
) (
	input wire SYS_CLK,
	input wire RST,
	input wire SCLK,
	input wire CS_N,
	input wire [3:0] IO_IN,
	output wire [3:0] IO_OUT,
	output wire [3:0] IO_OE,
	input wire [1:0] PROTOCOL,
	input wire BUSY,
	input wire ERASE_FAIL,
	input wire PROGRAM_FAIL,
	input wire PROTECT_FAIL,
	input wire [7:0] STATUS_BITS,
	input wire [7:0] LOCK_BITS,
	input wire [7:0] OTP_BYTE,
	output reg CMD_STROBE,
	output reg [7:0] CMD_CODE,
	output reg [31:0] CMD_ADDR,
	output reg [8:0] CMD_COUNT,
	output reg DATA_STROBE,
	output reg [7:0] DATA_BYTE,
	output reg [7:0] VCR,
	output reg [7:0] EVCR,
	output reg [15:0] NVCR,
	output reg [7:0] EAR,
	output reg ADDR4,
	output reg WEL,
	output reg [7:0] FLAG_STATUS
);
	// ======================================================================
	// phase codes
	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_OPC = 3'd1;
	localparam [2:0] ST_ADDR = 3'd2;
	localparam [2:0] ST_DUMMY = 3'd3;
	localparam [2:0] ST_DIN = 3'd4;
	localparam [2:0] ST_DOUT = 3'd5;
	localparam [2:0] ST_IGNORE = 3'd6;
	// ======================================================================
	// pin synchronisation
	wire [5:0] pins_s; // {sclk, ~cs_n, io}
	sfcd_sync #(.W(6)) u_sync (
		.clk(SYS_CLK),
		.rst(RST),
		.d({SCLK, ~CS_N, IO_IN}),
		.q(pins_s)
	);
	wire sclk_s = pins_s[5];
	wire cs_n_s = ~pins_s[4]; // inverted so reset idles high
	reg sclk_d; // previous sclk
	reg cs_d; // previous cs_n
	wire rise = sclk_s & ~sclk_d; // sample edge
	wire fall = ~sclk_s & sclk_d; // drive edge
	wire frame_start = cs_d & ~cs_n_s;
	wire frame_end = ~cs_d & cs_n_s;
	// ======================================================================
	// decode helpers
	// true when code is a legal write-type command needing the latch
	function needs_wel;
		input [7:0] op;
		begin
			case (op)
			`OP_WRSR, `OP_WRLR, `OP_WRNVCR, `OP_WRVCR, `OP_WREVCR,
			`OP_PP, `OP_PP4, `OP_DIFP, `OP_DIFP_X, `OP_QIFP, `OP_QIFP4, `OP_QIFP_X,
			`OP_SSE, `OP_SE, `OP_BE, `OP_RESUME, `OP_SUSPEND, `OP_PROTP:
				needs_wel = 1'b1;
			default:
				needs_wel = 1'b0;
			endcase
		end
	endfunction
	// legality per protocol; dual and quad aliases handled here
	function legal;
		input [7:0] op;
		input [1:0] pr;
		begin
			case (op)
			`OP_WREN, `OP_WRDI, `OP_RDSR, `OP_WRSR, `OP_RDLR, `OP_WRLR, `OP_RDFSR,
			`OP_CLFSR, `OP_RDNVCR, `OP_WRNVCR, `OP_RDVCR, `OP_WRVCR, `OP_RDEVCR,
			`OP_WREVCR, `OP_RDEAR, `OP_WREAR, `OP_PP, `OP_PP4, `OP_SSE, `OP_SE,
			`OP_BE, `OP_RESUME, `OP_SUSPEND, `OP_RDOTP, `OP_PROTP, `OP_EN4B, `OP_EX4B:
				legal = 1'b1;
			`OP_DIFP, `OP_DIFP_X:
				legal = (pr != `PROTO_QUAD);
			`OP_QIFP, `OP_QIFP4:
				legal = (pr != `PROTO_DUAL);
			`OP_QIFP_X:
				legal = (pr == `PROTO_QUAD) && ALT_VARIANT;
			default:
				legal = 1'b0;
			endcase
		end
	endfunction
	// address bytes per opcode
	function [2:0] addr_bytes;
		input [7:0] op;
		input a4;
		begin
			case (op)
			`OP_PP4, `OP_QIFP4:
				addr_bytes = 3'd4;
			`OP_PP, `OP_DIFP, `OP_DIFP_X, `OP_QIFP, `OP_QIFP_X, `OP_SSE, `OP_SE, `OP_BE,
			`OP_RDOTP, `OP_PROTP, `OP_RDLR, `OP_WRLR:
				addr_bytes = a4 ? 3'd4 : 3'd3;
			default:
				addr_bytes = 3'd0;
			endcase
		end
	endfunction
	// ======================================================================
	// state
	reg [2:0] state; // command phase
	reg [7:0] op; // latched opcode
	reg [2:0] acnt; // address bytes left
	reg [3:0] dcnt; // dummy clocks left
	reg [8:0] nbytes; // data bytes moved
	reg [15:0] nv_shadow; // nonvolatile write staging
	reg out_en; // drive data lines
	reg load; // shift unit load pulse
	reg [7:0] load_byte; // byte to send
	wire [7:0] in_byte;
	wire byte_done;
	wire [3:0] dout;
	wire [3:0] dummy_len = (OTP_DUMMY_CFG != 4'd0) ? OTP_DUMMY_CFG :
		(PROTOCOL == `PROTO_QUAD) ? `OTP_DUMMY_QUAD : `OTP_DUMMY_EXT;
	wire [7:0] status_view = {STATUS_BITS[7:2], WEL, BUSY};
	wire [7:0] flag_view = {~BUSY, FLAG_STATUS[6:1], ADDR4};
	// write opcodes whose frame carries a single data byte
	wire one_byte = (op == `OP_WRSR) || (op == `OP_WRLR) || (op == `OP_WRVCR) ||
		(op == `OP_WREVCR) || (op == `OP_WREAR);
	// shift engine, cleared at each frame boundary
	sfcd_shift u_shift (
		.clk(SYS_CLK),
		.rst(RST),
		.clear(frame_start | frame_end),
		.proto(PROTOCOL),
		.in_step(rise & ~cs_n_s),
		.din(pins_s[3:0]),
		.out_step(fall & out_en & ~load),
		.load(load),
		.load_byte(load_byte),
		.in_byte(in_byte),
		.byte_done(byte_done),
		.dout(dout)
	);
	// pin drive: ext uses the second line, dual the low two, quad all four
	assign IO_OUT = dout;
	assign IO_OE = ~out_en ? 4'h0 : (PROTOCOL == `PROTO_QUAD) ? 4'hF :
		(PROTOCOL == `PROTO_DUAL) ? 4'h3 : 4'h2;
	// byte to present for a read opcode at index n
	function [7:0] read_byte;
		input [7:0] o;
		input [8:0] n;
		input [7:0] sv;
		input [7:0] fv;
		begin
			case (o)
			`OP_RDSR: read_byte = sv;
			`OP_RDFSR: read_byte = fv;
			`OP_RDNVCR: read_byte = (n == 9'd0) ? NVCR[7:0] :
				(n == 9'd1) ? NVCR[15:8] : 8'h00;
			`OP_RDVCR: read_byte = VCR;
			`OP_RDEVCR: read_byte = EVCR;
			`OP_RDEAR: read_byte = EAR;
			`OP_RDLR: read_byte = LOCK_BITS;
			`OP_RDOTP: read_byte = (n < `OTP_BYTES) ? OTP_BYTE : 8'h00;
			default: read_byte = 8'h00;
			endcase
		end
	endfunction
	// sampled edges of the link clock and chip select
	always @(posedge SYS_CLK) begin
		if (RST) begin
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_d <= cs_n_s;
		end
	end
	// ======================================================================
	// command sequencer
	always @(posedge SYS_CLK) begin
		if (RST) begin
			state <= ST_IDLE;
			op <= 8'h00;
			acnt <= 3'd0;
			dcnt <= 4'd0;
			nbytes <= 9'd0;
			nv_shadow <= 16'h0000;
			out_en <= 1'b0;
			load <= 1'b0;
			load_byte <= 8'h00;
			CMD_STROBE <= 1'b0;
			CMD_CODE <= 8'h00;
			CMD_ADDR <= 32'h0000_0000;
			CMD_COUNT <= 9'd0;
			DATA_STROBE <= 1'b0;
			DATA_BYTE <= 8'h00;
			VCR <= `VCR_RESET;
			EVCR <= `EVCR_RESET;
			NVCR <= `NVCR_RESET;
			EAR <= `EAR_RESET;
			ADDR4 <= 1'b0;
			WEL <= 1'b0;
			FLAG_STATUS <= 8'h00;
		end else begin
			CMD_STROBE <= 1'b0;
			DATA_STROBE <= 1'b0;
			load <= 1'b0;
			// error flags: hardware set wins over the clear command
			if (ERASE_FAIL)
				FLAG_STATUS[`FSR_ERASE] <= 1'b1;
			if (PROGRAM_FAIL)
				FLAG_STATUS[`FSR_PROG] <= 1'b1;
			if (PROTECT_FAIL)
				FLAG_STATUS[`FSR_PROT] <= 1'b1;
			if (frame_start) begin
				state <= ST_OPC;
				nbytes <= 9'd0;
				CMD_ADDR <= 32'h0000_0000;
			end else if (frame_end) begin
				// output off at once; writes with a data phase launch on the rise
				out_en <= 1'b0;
				state <= ST_IDLE;
				if (state == ST_DIN && nbytes != 9'd0) begin
					CMD_STROBE <= 1'b1;
					CMD_CODE <= op;
					CMD_COUNT <= nbytes;
					WEL <= 1'b0;
					if (op == `OP_WRNVCR && nbytes == 9'd2)
						NVCR <= nv_shadow;
				end else if (state == ST_DIN || state == ST_ADDR) begin
					state <= ST_IDLE;
				end else if (state == ST_DUMMY && addr_bytes(op, ADDR4) != 3'd0) begin
					state <= ST_IDLE;
				end
				// opcode not completed: nothing happens
			end else if (byte_done) begin
				case (state)
				ST_OPC: begin
					op <= in_byte;
					if (!legal(in_byte, PROTOCOL)) begin
						state <= ST_IGNORE;
					end else if (needs_wel(in_byte) && !WEL) begin
						state <= ST_IGNORE;
					end else if (in_byte == `OP_WREAR && !WEL && !ALT_VARIANT) begin
						state <= ST_IGNORE;
					end else if (in_byte == `OP_RDLR && BUSY) begin
						state <= ST_IGNORE;
					end else begin
						case (in_byte)
						`OP_WREN: begin
							WEL <= 1'b1;
							state <= ST_IGNORE;
						end
						`OP_WRDI: begin
							WEL <= 1'b0;
							state <= ST_IGNORE;
						end
						`OP_CLFSR: begin
							FLAG_STATUS[`FSR_ERASE] <= ERASE_FAIL;
							FLAG_STATUS[`FSR_PROG] <= PROGRAM_FAIL;
							FLAG_STATUS[`FSR_PROT] <= PROTECT_FAIL;
							state <= ST_IGNORE;
						end
						`OP_EN4B: begin
							ADDR4 <= 1'b1;
							state <= ST_IGNORE;
						end
						`OP_EX4B: begin
							ADDR4 <= 1'b0;
							state <= ST_IGNORE;
						end
						`OP_RESUME, `OP_SUSPEND: begin
							CMD_STROBE <= 1'b1;
							CMD_CODE <= in_byte;
							CMD_COUNT <= 9'd0;
							WEL <= 1'b0;
							state <= ST_IGNORE;
						end
						default: begin
							acnt <= addr_bytes(in_byte, ADDR4);
							if (addr_bytes(in_byte, ADDR4) != 3'd0) begin
								state <= ST_ADDR;
							end else if (in_byte == `OP_RDSR || in_byte == `OP_RDFSR ||
								in_byte == `OP_RDNVCR || in_byte == `OP_RDVCR ||
								in_byte == `OP_RDEVCR || in_byte == `OP_RDEAR) begin
								state <= ST_DOUT;
								out_en <= 1'b1;
								load <= 1'b1;
								load_byte <= read_byte(in_byte, 9'd0, status_view, flag_view);
							end else begin
								state <= ST_DIN;
							end
						end
						endcase
					end
				end
				ST_ADDR: begin
					CMD_ADDR <= {CMD_ADDR[23:0], in_byte};
					acnt <= acnt - 3'd1;
					if (acnt == 3'd1) begin
						if (op == `OP_SSE || op == `OP_SE || op == `OP_BE) begin
							CMD_STROBE <= 1'b1;
							CMD_CODE <= op;
							CMD_COUNT <= 9'd0;
							WEL <= 1'b0;
							state <= ST_IGNORE;
						end else if (op == `OP_RDOTP) begin
							dcnt <= dummy_len;
							state <= ST_DUMMY;
						end else if (op == `OP_RDLR) begin
							state <= ST_DOUT;
							out_en <= 1'b1;
							load <= 1'b1;
							load_byte <= LOCK_BITS;
						end else begin
							state <= ST_DIN;
						end
					end
				end
				ST_DIN: begin
					// single-byte writes take exactly one byte; extras fall away
					if (!(one_byte && nbytes != 9'd0)) begin
						DATA_STROBE <= 1'b1;
						DATA_BYTE <= in_byte;
						if (nbytes != `PAGE_BYTES) nbytes <= nbytes + 9'd1;
						case (op)
						`OP_WRVCR: VCR <= in_byte;
						`OP_WREVCR: EVCR <= in_byte;
						`OP_WREAR: EAR <= in_byte;
						`OP_WRNVCR: nv_shadow <= (nbytes == 9'd0) ? {8'h00, in_byte} :
							{in_byte, nv_shadow[7:0]};
						default: ;
						endcase
					end
				end
				ST_DOUT: begin
					// a boundary right behind a load is the dummy tail, not data;
					// dummy counts that are not byte aligned are not supported
					if (!load) begin
						nbytes <= nbytes + 9'd1;
						load <= 1'b1;
						load_byte <= read_byte(op, nbytes + 9'd1, status_view, flag_view);
					end
				end
				default: ;
				endcase
			end else if (state == ST_DUMMY && rise) begin
				if (dcnt == 4'd1) begin
					state <= ST_DOUT;
					out_en <= 1'b1;
					load <= 1'b1;
					load_byte <= read_byte(op, 9'd0, status_view, flag_view);
				end
				dcnt <= dcnt - 4'd1;
			end
		end
	end
endmodule // sfcd_core

/* sfcd_core_sva.sv */
// sfcd_core_sva.sv: port checks for the command decoder.
// assumes one clock domain, reset synchronous and active high.
`timescale 1ns/10ps
module sfcd_core_sva (
	input wire SYS_CLK,
	input wire RST,
	input wire CS_N,
	input wire [1:0] PROTOCOL,
	input wire [3:0] IO_OE,
	input wire CMD_STROBE,
	input wire [7:0] CMD_CODE,
	input wire [8:0] CMD_COUNT,
	input wire WEL,
	input wire [7:0] VCR,
	input wire [15:0] NVCR,
	input wire ERASE_FAIL,
	input wire PROGRAM_FAIL,
	input wire [7:0] FLAG_STATUS
);
	// ====
	// helpers
	// lines the active protocol may drive
	wire [3:0] oe_exp = (PROTOCOL == 2'h2) ? 4'hF : (PROTOCOL == 2'h1) ? 4'h3 : 4'h2;
	// erase codes, all gated by the latch
	wire erase_op = CMD_CODE == 8'h20 || CMD_CODE == 8'hD8 || CMD_CODE == 8'hC7;
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	// ====
	// assertions
	// six cycles covers the two-stage sync plus the enable register
	a_oe_released: assert property (CS_N [*6] |-> IO_OE == 4'h0)
		else $error("output enable held while deselected");
	a_oe_lines: assert property (IO_OE != 4'h0 |-> IO_OE == oe_exp)
		else $error("wrong lines enabled for protocol");
	a_erase_gated: assert property (CMD_STROBE && erase_op |-> $past(WEL))
		else $error("erase launched without write enable");
	a_vcr_gated: assert property (!$past(RST) && VCR != $past(VCR) |-> $past(WEL))
		else $error("volatile config changed without write enable");
	a_nvcr_gated: assert property (!$past(RST) && NVCR != $past(NVCR) |-> $past(WEL))
		else $error("nonvolatile config changed without write enable");
	a_erase_flag: assert property (ERASE_FAIL |=> FLAG_STATUS[5])
		else $error("erase error flag not set");
	a_prog_flag: assert property (PROGRAM_FAIL |=> FLAG_STATUS[4])
		else $error("program error flag not set");
	a_flag_sticky: assert property (CS_N [*8] ##0 FLAG_STATUS[5] |=> FLAG_STATUS[5])
		else $error("error flag dropped with no command");
	a_page_cnt: assert property (CMD_COUNT <= 9'h100)
		else $error("page byte count above one page");
	// ====
	// coverage
	c_erase: cover property (CMD_STROBE && erase_op);
	c_quad: cover property (IO_OE == 4'hF);
	c_flag: cover property (FLAG_STATUS[5] && CS_N);
endmodule // sfcd_core_sva

bind sfcd_core sfcd_core_sva sfcd_core_sva_i (
	.SYS_CLK(SYS_CLK), .RST(RST), .CS_N(CS_N), .PROTOCOL(PROTOCOL), .IO_OE(IO_OE),
	.CMD_STROBE(CMD_STROBE), .CMD_CODE(CMD_CODE), .CMD_COUNT(CMD_COUNT), .WEL(WEL),
	.VCR(VCR), .NVCR(NVCR), .ERASE_FAIL(ERASE_FAIL), .PROGRAM_FAIL(PROGRAM_FAIL),
	.FLAG_STATUS(FLAG_STATUS)
);

/* flash_host_model.sv */
// flash_host_model.sv: host controller on the far side of the link.
// assumes the device samples sclk with its own faster clock.
`timescale 1ns/10ps
module flash_host_model (
	output reg sclk,
	output reg cs_n,
	output reg [3:0] io_in,
	input wire [3:0] io_out,
	input wire [1:0] protocol
);
	// ====
	// idle: deselected, clock parked low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h5;
	end
	// select, then let the device see it
	task automatic frame_open;
		begin
			cs_n = 1'b0;
			#100;
		end
	endtask
	// deselect may come at any point of output
	task automatic frame_close;
		begin
			#40;
			cs_n = 1'b1;
			#300;
		end
	endtask
	// msb first; bits per step follow the protocol
	task automatic shift(input [7:0] tx, input integer bits, input drive, output [7:0] rx);
		integer i;
		integer w;
		reg [7:0] t;
		reg [3:0] s;
		begin
			w = (protocol == 2'h2) ? 4 : (protocol == 2'h1) ? 2 : 1;
			t = tx;
			rx = 8'h00;
			for (i = 0; i < bits; i = i + w) begin
				// released lines toggle so stale levels never pass as data
				if (drive)
					io_in = (w == 4) ? t[7:4] : (w == 2) ? {~io_in[3:2], t[7:6]} : {~io_in[3:1], t[7]};
				else
					io_in = ~io_in;
				#62.5;
				sclk = 1'b1;
				s = (w == 4) ? io_out : (w == 2) ? {2'b00, io_out[1:0]} : {3'b000, io_out[1]};
				rx = (rx << w) | {4'h0, s};
				t = t << w;
				#62.5;
				sclk = 1'b0;
			end
		end
	endtask
endmodule // flash_host_model

/* sfcd_core_tb.sv */
// sfcd_core_tb.sv: self-checking bench for the command decoder.
// assumes the host model and checker are compiled alongside.
`timescale 1ns/10ps
module sfcd_core_tb;
	// ====
	// pins and bench state
	logic SYS_CLK = 1'b0;
	logic RST = 1'b1;
	logic [1:0] PROTOCOL = 2'h0;
	logic BUSY = 1'b0;
	logic ERASE_FAIL = 1'b0;
	logic PROGRAM_FAIL = 1'b0;
	logic PROTECT_FAIL = 1'b0;
	wire SCLK, CS_N, CMD_STROBE, DATA_STROBE, ADDR4, WEL;
	wire [3:0] host_io, IO_IN, IO_OUT, IO_OE;
	wire [7:0] CMD_CODE, DATA_BYTE, VCR, EVCR, EAR, FLAG_STATUS;
	wire [31:0] CMD_ADDR;
	wire [8:0] CMD_COUNT;
	wire [15:0] NVCR;
	integer error_cnt = 0;
	integer check_count = 0;
	integer strobes = 0;
	integer dcount = 0;
	integer k;
	integer n;
	logic [7:0] last_code;
	logic [31:0] last_addr;
	logic [23:0] rd;
	logic [3:0] oe;
	logic [7:0] r8;
	// program aliases per protocol; a2h is not a quad code
	logic [7:0] op_tab [6] = '{8'h02, 8'hA2, 8'hD2, 8'h02, 8'h32, 8'hA2};
	logic [1:0] pr_tab [6] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
	integer cnt_tab [6] = '{1, 1, 1, 1, 1, 0};
	always #2.5 SYS_CLK = ~SYS_CLK;
	// pin level: device wins where it enables, host elsewhere
	assign IO_IN = (IO_OE & IO_OUT) | (~IO_OE & host_io);
	sfcd_core sfcd_core_i (
		.SYS_CLK(SYS_CLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N), .IO_IN(IO_IN),
		.IO_OUT(IO_OUT), .IO_OE(IO_OE), .PROTOCOL(PROTOCOL), .BUSY(BUSY),
		.ERASE_FAIL(ERASE_FAIL), .PROGRAM_FAIL(PROGRAM_FAIL), .PROTECT_FAIL(PROTECT_FAIL),
		.STATUS_BITS(8'hA4), .LOCK_BITS(8'h3C), .OTP_BYTE(8'h5A), .CMD_STROBE(CMD_STROBE),
		.CMD_CODE(CMD_CODE), .CMD_ADDR(CMD_ADDR), .CMD_COUNT(CMD_COUNT),
		.DATA_STROBE(DATA_STROBE), .DATA_BYTE(DATA_BYTE), .VCR(VCR), .EVCR(EVCR),
		.NVCR(NVCR), .EAR(EAR), .ADDR4(ADDR4), .WEL(WEL), .FLAG_STATUS(FLAG_STATUS)
	);
	flash_host_model flash_host_model_i (
		.sclk(SCLK), .cs_n(CS_N), .io_in(host_io), .io_out(IO_IN), .protocol(PROTOCOL)
	);
	// record launches and received data bytes
	always @(posedge SYS_CLK) begin
		if (CMD_STROBE === 1'b1) begin
			strobes <= strobes + 1;
			last_code <= CMD_CODE;
			last_addr <= CMD_ADDR;
		end
		if (DATA_STROBE === 1'b1)
			dcount <= dcount + 1;
	end
	// ====
	// tasks
	task automatic tick(input integer c);
		begin
			repeat (c) @(posedge SYS_CLK);
			#1;
		end
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		begin
			check_count++;
			if (seen !== exp) begin
				error_cnt++;
				$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	// one frame: opcode, nw bytes out of wd, then nr bytes read
	task automatic cmd(input [7:0] op, input [39:0] wd, input integer nw, input integer nr);
		logic [7:0] r;
		logic [39:0] w;
		integer i;
		begin
			w = wd << (8 * (5 - nw));
			rd = 24'h0;
			flash_host_model_i.frame_open;
			flash_host_model_i.shift(op, 8, 1'b1, r);
			for (i = 0; i < nw; i++) begin
				flash_host_model_i.shift(w[39:32], 8, 1'b1, r);
				w = w << 8;
			end
			for (i = 0; i < nr; i++) begin
				flash_host_model_i.shift(8'h00, 8, 1'b0, r);
				rd = {rd[15:0], r};
			end
			oe = IO_OE;
			flash_host_model_i.frame_close;
		end
	endtask
	task automatic wren;
		cmd(8'h06, 40'h0, 0, 0);
	endtask
	task automatic report_and_stop;
		begin
			$display("checks %0d errors %0d", check_count, error_cnt);
			if (error_cnt == 0 && check_count > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// ====
	// watchdog, nearly four times the expected run
	initial begin
		#450000;
		error_cnt++;
		report_and_stop;
	end
	// ====
	// scenarios
	initial begin
		tick(2);
		RST = 1'b0;
		tick(3);
		check("vcr_rst", VCR, 8'hFB);
		check("evcr_rst", EVCR, 8'hFF);
		check("nvcr_rst", NVCR, 16'hFFFF);
		check("ear_rst", EAR, 8'h00);
		cmd(8'h81, 40'h55, 1, 0);
		check("vcr_gated", VCR, 8'hFB);
		flash_host_model_i.frame_open;
		flash_host_model_i.shift(8'h06, 4, 1'b1, r8);
		flash_host_model_i.frame_close;
		check("wel_abort", WEL, 1'b0);
		wren;
		tick(1);
		BUSY = 1'b1;
		cmd(8'h05, 40'h0, 0, 2);
		check("status", rd[15:0], 16'hA7A7);
		check("oe_ext", oe, 4'h2);
		check("oe_off", IO_OE, 4'h0);
		tick(1);
		ERASE_FAIL = 1'b1;
		PROGRAM_FAIL = 1'b1;
		PROTECT_FAIL = 1'b1;
		tick(1);
		ERASE_FAIL = 1'b0;
		PROGRAM_FAIL = 1'b0;
		PROTECT_FAIL = 1'b0;
		tick(8);
		check("flags_set", {FLAG_STATUS[5:4], FLAG_STATUS[1]}, 3'h7);
		cmd(8'h70, 40'h0, 0, 1);
		check("flag_rd", rd[7:0], 8'h32);
		tick(1);
		BUSY = 1'b0;
		cmd(8'h50, 40'h0, 0, 0);
		check("flags_clr", {FLAG_STATUS[5:4], FLAG_STATUS[1]}, 3'h0);
		wren;
		cmd(8'h81, 40'h12, 1, 0);
		check("vcr_wr", VCR, 8'h12);
		cmd(8'h85, 40'h0, 0, 2);
		check("vcr_rd", rd[15:0], 16'h1212);
		wren;
		cmd(8'h61, 40'hEF, 1, 0);
		cmd(8'h65, 40'h0, 0, 1);
		check("evcr_rd", rd[7:0], 8'hEF);
		wren;
		cmd(8'hB1, 40'h3412, 2, 0);
		check("nvcr_wr", NVCR, 16'h1234);
		cmd(8'hB5, 40'h0, 0, 3);
		check("nvcr_rd", rd, 24'h34_1200);
		n = dcount;
		wren;
		cmd(8'h01, 40'h1C, 1, 0);
		wren;
		cmd(8'hE5, 40'h00_0000_0001, 4, 0);
		check("reg_bytes", dcount - n, 2);
		wren;
		cmd(8'h20, 40'h01_0203, 3, 0);
		check("sse_code", last_code, 8'h20);
		check("sse_addr", last_addr, 32'h0001_0203);
		cmd(8'hB7, 40'h0, 0, 0);
		check("addr4_on", ADDR4, 1'b1);
		wren;
		cmd(8'hD8, 40'h0A0B_0C0D, 4, 0);
		check("se_addr", last_addr, 32'h0A0B_0C0D);
		cmd(8'hE9, 40'h0, 0, 0);
		check("addr4_off", ADDR4, 1'b0);
		wren;
		cmd(8'hC7, 40'h0, 3, 0);
		check("be_code", last_code, 8'hC7);
		wren;
		cmd(8'h04, 40'h0, 0, 0);
		check("wel_off", WEL, 1'b0);
		n = strobes;
		cmd(8'h20, 40'h01_0203, 3, 0);
		check("sse_gated", strobes - n, 0);
		wren;
		cmd(8'h12, 40'h01_0203_0405, 5, 0);
		check("pp4_addr", last_addr, 32'h0102_0304);
		check("pp4_cnt", CMD_COUNT, 9'h001);
		cmd(8'h4B, 40'h0, 3, 2);
		check("otp", rd[7:0], 8'h5A);
		wren;
		cmd(8'hC5, 40'h01, 1, 0);
		cmd(8'hC8, 40'h0, 0, 1);
		check("ear_rd", rd[7:0], 8'h01);
		cmd(8'hE8, 40'h0, 3, 1);
		check("lock_rd", rd[7:0], 8'h3C);
		cmd(8'h00, 40'h0, 0, 1);
		check("unknown_oe", oe, 4'h0);
		for (k = 0; k < 6; k++) begin
			tick(1);
			PROTOCOL = pr_tab[k];
			wren;
			n = dcount;
			cmd(op_tab[k], 40'h0010_00C3, 4, 0);
			check("prog", dcount - n, cnt_tab[k]);
		end
		check("prog_data", DATA_BYTE, 8'hC3);
		cmd(8'h85, 40'h0, 0, 1);
		check("quad_rd", rd[7:0], 8'h12);
		check("oe_quad", oe, 4'hF);
		report_and_stop;
	end
endmodule // sfcd_core_tb
